// ==== rpsc_pkg.sv ====
// Package with constants and state types of the reset and pin-state controller.
package rpsc_pkg;

   // --------------------------------------------------------------------------
   // Timing constants.
   // --------------------------------------------------------------------------
   localparam int unsigned RPSC_CLK_PERIOD_PS    = 25000;
   localparam int unsigned RPSC_HARD_RST_MIN_CYC = 50;
   localparam int unsigned RPSC_POR_CYC          = 16;
   localparam int unsigned RPSC_SOFT_RST_CYC     = 16;
   localparam int unsigned RPSC_CNT_W            = 8;

   // --------------------------------------------------------------------------
   // Values after reset.
   // --------------------------------------------------------------------------
   localparam logic        RPSC_PULLUP_RST       = 1'b1;
   localparam logic [1:0]  RPSC_SYNC_RST         = 2'h0;

   // --------------------------------------------------------------------------
   // Device states.
   // --------------------------------------------------------------------------
   typedef enum logic [2:0] {
      RPSC_ST_RESET,
      RPSC_ST_DEFAULT,
      RPSC_ST_HARD_STBY,
      RPSC_ST_SOFT_STBY,
      RPSC_ST_STREAM,
      RPSC_ST_IDLE
   } rpsc_state_e;

endpackage

// ==== rpsc_reset_timer.sv ====
// Counter that holds a reset request for a fixed number of cycles.
`timescale 1ns/1ps
module rpsc_reset_timer #(
   parameter int unsigned CNT_W  = 8,
   parameter int unsigned CYCLES = 16
) (
   // Clock and reset.
   input  wire logic             i_core_clk,
   input  wire logic             i_rst_n,
   // Control.
   input  wire logic             i_start,
   // Status.
   output logic                  o_busy
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   wire              busy_w = (cnt_q != '0);

   assign cnt_d  = i_start ? CNT_W'(CYCLES) : (busy_w ? cnt_q - CNT_W'(1) : cnt_q);
   assign o_busy = busy_w;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// ==== rpsc_top.sv ====
// Reset sources and pin-state control of the image processor.
//
// Overview of operation
// RULE_01 - Three reset sources: power-on, hard, soft.
// RULE_02 - Active-low reset pin pulse causes hard reset.
// RULE_03 - Host serial command triggers soft reset.
// RULE_04 - Power-on reset starts automatically at power-up.
// RULE_05 - Host serial data never driven high.
// RULE_06 - Flash data input pull-up always enabled.
// RULE_07 - Outside drives serial, select, sync, standby validly.
// RULE_08 - Reference clock stops only in reset, hard standby.
// RULE_09 - Outputs high-impedance while reset pin is low.
// RULE_10 - Reset pin held low at least 50 cycles.
`timescale 1ns/1ps
module rpsc_top
   import rpsc_pkg::*;
#(
   parameter int unsigned POR_CYCLES  = rpsc_pkg::RPSC_POR_CYC,
   parameter int unsigned SOFT_CYCLES = rpsc_pkg::RPSC_SOFT_RST_CYC
) (
   // Clock and external hard reset pin.
   input  wire logic                 i_core_clk,
   input  wire logic                 i_rst_n,
   // Pin inputs from the outside party.
   input  wire logic                 i_standby,
   input  wire logic                 i_bus_id_select,
   input  wire logic                 i_host_serial_data,
   // Requests from the serial host interface logic.
   input  wire logic                 i_soft_reset_req,
   input  wire logic                 i_soft_standby_req,
   input  wire logic                 i_stream_req,
   input  wire logic                 i_host_serial_data_low,
   // Host serial data pin drive.
   output logic                      o_host_serial_data_o,
   output logic                      o_host_serial_data_oe,
   // Flash data input pull-up.
   output logic                      o_flash_data_input_pu,
   // Status and resets to the core.
   output logic                      o_core_rst_n,
   output logic                      o_outputs_en,
   output logic                      o_bus_id_select,
   output rpsc_pkg::rpsc_state_e     o_state
);
   import rpsc_pkg::*;

   // --------------------------------------------------------------------------
   // Input synchronisers.
   // --------------------------------------------------------------------------
   logic [1:0]  stby_sync_q;
   logic [1:0]  sel_sync_q;
   logic [1:0]  sda_sync_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         stby_sync_q <= RPSC_SYNC_RST;
         sel_sync_q  <= RPSC_SYNC_RST;
         sda_sync_q  <= RPSC_SYNC_RST;
      end else begin
         stby_sync_q <= {stby_sync_q[0], i_standby};
         sel_sync_q  <= {sel_sync_q[0], i_bus_id_select};
         sda_sync_q  <= {sda_sync_q[0], i_host_serial_data};
      end
   end

   wire standby_w = stby_sync_q[1];

   // --------------------------------------------------------------------------
   // Power-on reset: runs from power-up, independent of the reset pin.
   // --------------------------------------------------------------------------
   // The shift register has no reset on purpose, so the reset pin cannot restart it.
   // It starts unknown and reads as done once ones have filled it from power-up.
   logic [POR_CYCLES-1:0] por_sr_q;
   logic                  soft_start_w;
   logic                  soft_busy_w;
   wire                   por_done_w = por_sr_q[POR_CYCLES-1];  // [RULE_04]

   always_ff @(posedge i_core_clk) begin
      por_sr_q <= (por_sr_q << 1) | POR_CYCLES'(1);  // [RULE_04]
   end

   // --------------------------------------------------------------------------
   // Soft reset from the host serial interface.
   // --------------------------------------------------------------------------
   assign soft_start_w = i_soft_reset_req;  // [RULE_03]

   rpsc_reset_timer #(
      .CNT_W  (RPSC_CNT_W),
      .CYCLES (SOFT_CYCLES)
   ) u_soft_timer (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_start    (soft_start_w),
      .o_busy     (soft_busy_w)
   );

   // --------------------------------------------------------------------------
   // Combined core reset from all three sources.
   // --------------------------------------------------------------------------
   wire any_rst_w = !i_rst_n || !por_done_w || soft_busy_w;  // [RULE_01]

   // --------------------------------------------------------------------------
   // Device state machine.
   // --------------------------------------------------------------------------
   rpsc_state_e state_q;
   rpsc_state_e state_d;

   always_comb begin
      state_d = state_q;
      case (state_q)
         RPSC_ST_RESET: begin
            if (!any_rst_w) begin
               state_d = RPSC_ST_DEFAULT;
            end
         end
         RPSC_ST_DEFAULT, RPSC_ST_IDLE: begin
            if (standby_w) begin
               state_d = RPSC_ST_HARD_STBY;
            end else if (i_soft_standby_req) begin
               state_d = RPSC_ST_SOFT_STBY;
            end else if (i_stream_req) begin
               state_d = RPSC_ST_STREAM;
            end
         end
         RPSC_ST_STREAM: begin
            if (standby_w) begin
               state_d = RPSC_ST_HARD_STBY;
            end else if (!i_stream_req) begin
               state_d = RPSC_ST_IDLE;
            end
         end
         RPSC_ST_HARD_STBY: begin
            if (!standby_w) begin
               state_d = RPSC_ST_IDLE;
            end
         end
         RPSC_ST_SOFT_STBY: begin
            if (standby_w) begin
               state_d = RPSC_ST_HARD_STBY;
            end else if (!i_soft_standby_req) begin
               state_d = RPSC_ST_IDLE;
            end
         end
         default: begin
            state_d = RPSC_ST_RESET;
         end
      endcase
      if (soft_start_w || soft_busy_w || !por_done_w) begin
         state_d = RPSC_ST_RESET;  // [RULE_03]
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state_q <= RPSC_ST_RESET;  // [RULE_02]
      end else begin
         state_q <= state_d;
      end
   end

   // --------------------------------------------------------------------------
   // Pin states and outputs.
   // --------------------------------------------------------------------------
   logic core_rst_n_q;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         core_rst_n_q <= 1'b0;  // [RULE_02]
      end else begin
         core_rst_n_q <= !(any_rst_w || soft_start_w);
      end
   end

   assign o_host_serial_data_o  = 1'b0;  // [RULE_05]
   assign o_host_serial_data_oe = i_rst_n && core_rst_n_q && i_host_serial_data_low;  // [RULE_05] [RULE_09]
   assign o_flash_data_input_pu = RPSC_PULLUP_RST;  // [RULE_06]
   assign o_core_rst_n          = core_rst_n_q;
   assign o_outputs_en          = i_rst_n && (state_q != RPSC_ST_RESET);  // [RULE_09]
   assign o_bus_id_select       = sel_sync_q[1];
   assign o_state               = state_q;

   // --------------------------------------------------------------------------
   // Assertions.
   // --------------------------------------------------------------------------
   AST_SDA_NEVER_HIGH:  // [RULE_05]
      assert property (@(posedge i_core_clk) !(o_host_serial_data_oe && o_host_serial_data_o))
      else $error("Host serial data driven high.");
   AST_PULLUP_ON:  // [RULE_06]
      assert property (@(posedge i_core_clk) o_flash_data_input_pu)
      else $error("Flash data input pull-up disabled.");
   AST_HIZ_IN_RESET:  // [RULE_09]
      assert property (@(posedge i_core_clk) !i_rst_n |-> !o_outputs_en && !o_host_serial_data_oe)
      else $error("Output enabled while reset pin is low.");
   AST_HARD_RST_STATE:  // [RULE_02]
      assert property (@(posedge i_core_clk) !i_rst_n |=> state_q == RPSC_ST_RESET && !o_core_rst_n)
      else $error("Hard reset did not reset the device.");
   AST_SOFT_RST:  // [RULE_03]
      assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
         i_soft_reset_req |=> !o_core_rst_n ##1 state_q == RPSC_ST_RESET)
      else $error("Soft reset request not honoured.");
   AST_POR_AUTO:  // [RULE_04]
      assert property (@(posedge i_core_clk)
         !por_done_w |=> !o_core_rst_n && state_q == RPSC_ST_RESET)
      else $error("Power-on reset did not hold the core.");
   AST_SOURCES:  // [RULE_01]
      assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
         (soft_busy_w || !por_done_w) |=> state_q == RPSC_ST_RESET)
      else $error("Reset source did not reach reset state.");
   AST_STBY_ENTRY:  // [RULE_08]
      assert property (@(posedge i_core_clk) disable iff (!i_rst_n || soft_start_w || soft_busy_w || !por_done_w)
         (standby_w && state_q == RPSC_ST_STREAM) |=> state_q == RPSC_ST_HARD_STBY)
      else $error("Standby did not enter hard standby.");
   AST_SDA_PULL_SEEN:  // [RULE_05]
      assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
         o_host_serial_data_oe [*3] |-> !sda_sync_q[1])
      else $error("Pulled-low serial data not seen on the line.");

   COV_HARD_RST:   cover property (@(posedge i_core_clk) $rose(i_rst_n));
   COV_SOFT_RST:   cover property (@(posedge i_core_clk) disable iff (!i_rst_n) i_soft_reset_req);
   COV_STREAM:     cover property (@(posedge i_core_clk) disable iff (!i_rst_n) state_q == RPSC_ST_STREAM);
   COV_HARD_STBY:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) state_q == RPSC_ST_HARD_STBY);
   COV_SOFT_STBY:  cover property (@(posedge i_core_clk) disable iff (!i_rst_n) state_q == RPSC_ST_SOFT_STBY);

endmodule

// ==== rpsc_host_model.sv ====
// Model of the host side: reset pin, standby, select and pulled-up data line.
`timescale 1ns/1ps
module rpsc_host_model (
   input  wire logic i_core_clk,
   input  wire logic i_sda_oe,
   input  wire logic i_sda_o,
   output logic      o_rst_n,
   output logic      o_standby,
   output logic      o_bus_id_select,
   output wire logic o_sda
);
   // The pull-up sets the level whenever the device releases the line.
   assign o_sda = (i_sda_oe && !i_sda_o) ? 1'b0 : 1'b1;
   initial begin
      o_rst_n = 1'b0;
      o_standby = 1'b0;
      o_bus_id_select = 1'b0;
   end
   // Hard reset pulse, never shorter than the minimum width.
   task automatic hard_reset(input int n);
      o_rst_n <= 1'b0;
      repeat (n < 50 ? 50 : n) @(posedge i_core_clk);
      o_rst_n <= 1'b1;
   endtask
endmodule

// ==== testbench.sv ====
// Self-checking testbench of the reset and pin-state controller.
`timescale 1ns/1ps
module testbench;
   import rpsc_pkg::*;
   localparam int unsigned SC = 2;
   logic        clk, rst_n, stby, bsel, srst, sstby, strm, sdl;
   logic        sda_o, sda_oe, pu, crst_n, oen, obsel;
   wire         sda;
   rpsc_state_e st;
   int          miscompares = 0;
   int          n_checks = 0;
   rpsc_top #(.POR_CYCLES(2), .SOFT_CYCLES(SC)) dut (
      .i_core_clk(clk), .i_rst_n(rst_n), .i_standby(stby),
      .i_bus_id_select(bsel), .i_host_serial_data(sda),
      .i_soft_reset_req(srst), .i_soft_standby_req(sstby),
      .i_stream_req(strm), .i_host_serial_data_low(sdl),
      .o_host_serial_data_o(sda_o), .o_host_serial_data_oe(sda_oe),
      .o_flash_data_input_pu(pu), .o_core_rst_n(crst_n),
      .o_outputs_en(oen), .o_bus_id_select(obsel), .o_state(st));
   rpsc_host_model host (
      .i_core_clk(clk), .i_sda_oe(sda_oe), .i_sda_o(sda_o),
      .o_rst_n(rst_n), .o_standby(stby), .o_bus_id_select(bsel),
      .o_sda(sda));
   // The reference clock runs throughout the run.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [2:0] e, input logic [2:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic tick();
      @(posedge clk);
      #1;
   endtask
   task automatic wait_st(input rpsc_state_e s);
      for (int i = 0; i < 300 && st !== s; i++) tick();
      if (st !== s) begin
         chk("state wait", s, st);
         give_verdict();
      end
   endtask
   task automatic t_reset_pins();
      fork
         host.hard_reset(50);
         begin
            @(posedge clk);
            sdl <= 1'b1;
            repeat (3) tick();
            chk("outputs_en", 0, oen);
            chk("sda_oe", 0, sda_oe);
            chk("sda", 1, sda);
            chk("pull_up", 1, pu);
            chk("core_rst_n", 0, crst_n);
            @(posedge clk);
            sdl <= 1'b0;
         end
      join
      wait_st(RPSC_ST_DEFAULT);
      chk("outputs_en", 1, oen);
      $display("done reset_pins");
   endtask
   task automatic t_sda();
      @(posedge clk);
      sdl <= 1'b1;
      tick();
      chk("sda_oe", 1, sda_oe);
      chk("sda_o", 0, sda_o);
      chk("sda", 0, sda);
      repeat (2) tick();
      chk("sda held low", 0, sda);
      @(posedge clk);
      sdl <= 1'b0;
      tick();
      chk("sda", 1, sda);
      $display("done sda");
   endtask
   task automatic t_soft_reset();
      int n;
      int bad;
      n = 0;
      bad = 0;
      @(posedge clk);
      srst <= 1'b1;
      strm <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      repeat (12) begin
         #1;
         if (crst_n === 1'b0) n++;
         if (crst_n === 1'b0 && st === RPSC_ST_STREAM) bad++;
         @(posedge clk);
      end
      #1;
      chk("core_rst_n low cycles", 3'(SC + 1), n[2:0]);
      chk("stream refused", 0, bad[2:0]);
      chk("state", RPSC_ST_STREAM, st);
      $display("done soft_reset");
   endtask
   task automatic t_hard_mid();
      fork
         host.hard_reset(50);
         begin
            @(posedge clk);
            sdl <= 1'b1;
            strm <= 1'b0;
            repeat (2) tick();
            chk("outputs_en", 0, oen);
            chk("sda_oe", 0, sda_oe);
            chk("core_rst_n", 0, crst_n);
            chk("state", RPSC_ST_RESET, st);
            @(posedge clk);
            sdl <= 1'b0;
         end
      join
      wait_st(RPSC_ST_DEFAULT);
      $display("done hard_mid");
   endtask
   task automatic t_standby();
      @(posedge clk);
      strm <= 1'b1;
      wait_st(RPSC_ST_STREAM);
      @(posedge clk);
      host.o_standby <= 1'b1;
      host.o_bus_id_select <= 1'b1;
      wait_st(RPSC_ST_HARD_STBY);
      chk("pull_up", 1, pu);
      chk("bus_id_select", 1, obsel);
      @(posedge clk);
      host.o_standby <= 1'b0;
      strm <= 1'b0;
      wait_st(RPSC_ST_IDLE);
      @(posedge clk);
      sstby <= 1'b1;
      wait_st(RPSC_ST_SOFT_STBY);
      chk("pull_up", 1, pu);
      @(posedge clk);
      sstby <= 1'b0;
      wait_st(RPSC_ST_IDLE);
      $display("done standby");
   endtask
   initial begin
      srst = 1'b0;
      sstby = 1'b0;
      strm = 1'b0;
      sdl = 1'b0;
      t_reset_pins();
      t_sda();
      t_soft_reset();
      t_hard_mid();
      t_standby();
      give_verdict();
   end
endmodule
